/* core/flash_iap_regs.svh */
// register offsets, field positions, codes and timing figures of the flash controller
`ifndef FLASH_IAP_REGS_SVH
`define FLASH_IAP_REGS_SVH
`define OFF_CTRL 8'h00
`define OFF_ADDR_LO 8'h04
`define OFF_ADDR_HI 8'h08
`define OFF_DATA_FIRST 8'h0c
`define OFF_DATA_LAST 8'h28
`define OFF_INT_STAT 8'h2c
`define OFF_INT_MASK 8'h30
`define CTRL_UNLOCKED 7
`define CTRL_ARM 3
`define CTRL_WSTART 2
`define CTRL_RD_EN 1
`define CTRL_RSTART 0
`define OP_WRITE 3'h0
`define OP_ERASE 3'h1
`define OP_READ 3'h3
`define OP_UNLOCK 3'h6
`define KEY0 8'h00
`define KEY1 8'h04
`define KEY2 8'h0d
`define KEY3 8'h09
`define KEY4 8'hc3
`define KEY5 8'h40
`define KEY_LAST 3'h5
`define KEY_FIRST_SLOT 3'h2
`define INT_PASS 0
`define INT_FAIL 1
`define INT_DONE 2
`define BLOCK_BASE 8'h00
`define UNLOCK_TIMEOUT_US 300
`define US_PER_S 1000000
`define SUB_CLK_HZ 32000
`define AXI_OKAY 2'h0
`define AXI_SLVERR 2'h2
`endif

/* core/flash_iap_pkg.sv */
// types shared by the flash reprogramming controller
package flash_iap_pkg;
	typedef enum logic [1:0] {FOP_WRITE = 2'h0, FOP_ERASE = 2'h1, FOP_READ = 2'h2} flash_op_t;
	typedef enum logic {CHK_IDLE = 1'h0, CHK_RUN = 1'h1} chk_state_t;
	typedef enum logic {FL_IDLE = 1'h0, FL_BUSY = 1'h1} fl_state_t;
	typedef struct packed {logic s1; logic s2; logic s3; logic tick;} sync_t;
	typedef struct packed {
		chk_state_t st; logic [2:0] idx; logic [7:0] ticks; logic pass; logic fail;
	} chk_t;
	typedef struct packed {
		logic aw_got; logic w_got; logic [7:0] aw_addr; logic [7:0] w_byte; logic w_en;
		logic awready; logic wready; logic bvalid; logic [1:0] bresp;
		logic arready; logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
		logic unlocked; logic [2:0] op_sel; logic arm; logic wr_start; logic rd_en; logic rd_start;
		logic [7:0] addr_lo; logic [3:0] addr_hi; logic [3:0][15:0] data;
		logic [2:0] int_stat; logic [2:0] int_mask; logic irq; logic halt;
		fl_state_t fl; logic flash_req; flash_op_t flash_op; logic [11:0] flash_addr;
		logic [15:0] flash_wdata;
		logic key_start; logic key_we; logic [2:0] key_idx; logic [7:0] key_byte;
	} top_t;
endpackage

/* core/iap_link_if.sv */
// link between the controller, the sub clock tick source and the key checker
interface iap_link_if;
	logic tick;
	logic start;
	logic key_we;
	logic [2:0] key_idx;
	logic [7:0] key_byte;
	logic pass;
	logic fail;
	modport sync_side (output tick);
	modport key_chk (input tick, start, key_we, key_idx, key_byte, output pass, fail);
	modport ctrl (output start, key_we, key_idx, key_byte, input tick, pass, fail);
endinterface

/* core/sub_tick_sync.sv */
// synchronises the slow sub clock and emits one pulse per rising edge of it
module sub_tick_sync (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic slow_sub_clock,
	iap_link_if.sync_side lk
);
	flash_iap_pkg::sync_t r;
	flash_iap_pkg::sync_t n;

	always_comb begin
		n.s1 = slow_sub_clock;
		n.s2 = r.s1;
		n.s3 = r.s2;
		n.tick = r.s2 & ~r.s3;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign lk.tick = r.tick;
endmodule // sub_tick_sync

/* core/unlock_key_checker.sv */
// checks the unlock key byte by byte against a sub clock timeout
`include "flash_iap_regs.svh"
module unlock_key_checker #(
	parameter int TIMEOUT_TICKS = 9
) (
	input wire logic core_clk,
	input wire logic rst_b,
	iap_link_if.key_chk lk
);
	localparam logic [7:0] LAST_TICK = 8'(TIMEOUT_TICKS - 1);
	flash_iap_pkg::chk_t r;
	flash_iap_pkg::chk_t n;

	if (TIMEOUT_TICKS < 1 || TIMEOUT_TICKS > 255) begin : g_bad_timeout
		$error("timeout tick count out of range");
	end

	function automatic logic [7:0] key_at(input logic [2:0] i);
		case (i)
			3'h0: key_at = `KEY0;
			3'h1: key_at = `KEY1;
			3'h2: key_at = `KEY2;
			3'h3: key_at = `KEY3;
			3'h4: key_at = `KEY4;
			default: key_at = `KEY5;
		endcase
	endfunction

	always_comb begin
		n = r;
		n.pass = 1'b0;
		n.fail = 1'b0;
		case (r.st)
			flash_iap_pkg::CHK_IDLE: begin
				n.st = flash_iap_pkg::CHK_IDLE;
			end
			flash_iap_pkg::CHK_RUN: begin
				if (lk.tick) begin
					n.ticks = r.ticks + 8'h01;
				end
				// overflow beats a key byte landing in the same cycle
				if (lk.tick && r.ticks == LAST_TICK) begin // R4
					n.fail = 1'b1; // R5
					n.st = flash_iap_pkg::CHK_IDLE;
				end else if (lk.key_we) begin
					if (lk.key_idx != r.idx || lk.key_byte != key_at(r.idx)) begin // R3
						n.fail = 1'b1; // R19
						n.st = flash_iap_pkg::CHK_IDLE;
					end else if (r.idx == `KEY_LAST) begin
						n.pass = 1'b1; // R6
						n.st = flash_iap_pkg::CHK_IDLE;
					end else begin
						n.idx = r.idx + 3'h1;
					end
				end
			end
		endcase
		if (lk.start) begin
			n.st = flash_iap_pkg::CHK_RUN;
			n.idx = 3'h0;
			n.ticks = 8'h00;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign lk.pass = r.pass;
	assign lk.fail = r.fail;

	timeout_fail_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R4
		(r.st == flash_iap_pkg::CHK_RUN && lk.tick && r.ticks == LAST_TICK) |=> lk.fail)
		else $error("timeout did not fail the unlock");
	bad_byte_a: assert property (@(posedge core_clk) disable iff (!rst_b) // R19
		(r.st == flash_iap_pkg::CHK_RUN && !lk.start && !lk.tick && lk.key_we
		&& lk.key_byte != key_at(r.idx)) |=> (lk.fail && !lk.pass))
		else $error("wrong key byte not failed");
endmodule // unlock_key_checker

/* core/flash_iap_unlock_erase_ctrl.sv */
// in-field reprogramming controller: register slave, unlock sequence, erase/write/read
// Behaviour
// R1 - op select 110 with arm requests the unlock sequence.
// R2 - op select and arm bit are accepted in one register write.
// R3 - software writes key 00,04,0d,09,c3,40 into data words 1 to 3, low first.
// R4 - arming starts a 300 us timeout counted on the slow sub clock.
// R5 - overflow or wrong byte keeps writing locked and clears the arm bit.
// R6 - full correct key in time unlocks writing and clears the arm bit.
// R7 - successful unlock sets the write-unlocked flag.
// R8 - software clearing the flag locks writing again.
// R9 - no erase or write reaches the array while locked.
// R10 - software erases a block before writing words inside it.
// R11 - a block erase clears 256 consecutive words.
// R12 - erase block comes from the high address only; low address ignored.
// R13 - the cpu halts while write-start or read-start is set.
// R14 - data word 3 high holds bits 15 to 8, resets to zero.
// R15 - op select 000 writes, 001 erases, 011 reads; others reserved.
// R16 - hardware clears write-start when the operation finishes.
// R17 - hardware clears read-start once data word 0 holds the read word.
// R18 - writing one to the write-unlocked flag does nothing.
// R19 - each key byte is checked on arrival; first mismatch fails.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`include "flash_iap_regs.svh"
module flash_iap_unlock_erase_ctrl #(
	parameter int ADDR_HI_W = 3,
	parameter int SUB_CLK_HZ = `SUB_CLK_HZ
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic slow_sub_clock,
	output logic flash_req,
	output flash_iap_pkg::flash_op_t flash_op,
	output logic [11:0] flash_addr,
	output logic [15:0] flash_wdata,
	input wire logic [15:0] flash_rdata,
	input wire logic flash_done,
	output logic cpu_halt,
	output logic irq
);
	// longest time rounds down so the window never exceeds the figure
	localparam int TIMEOUT_TICKS = (`UNLOCK_TIMEOUT_US * SUB_CLK_HZ) / `US_PER_S;
	localparam logic [3:0] HI_MASK = 4'((1 << ADDR_HI_W) - 1);

	if (ADDR_HI_W < 3 || ADDR_HI_W > 4) begin : g_bad_addr_w
		$error("ADDR_HI_W must be 3 or 4");
	end
	if (TIMEOUT_TICKS < 1) begin : g_bad_sub_clk
		$error("sub clock too slow for the unlock timeout");
	end

	flash_iap_pkg::top_t r;
	flash_iap_pkg::top_t n;
	iap_link_if lk();

	sub_tick_sync u_tick (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.slow_sub_clock(slow_sub_clock),
		.lk(lk)
	);

	unlock_key_checker #(
		.TIMEOUT_TICKS(TIMEOUT_TICKS)
	) u_key (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.lk(lk)
	);

	assign lk.start = r.key_start;
	assign lk.key_we = r.key_we;
	assign lk.key_idx = r.key_idx;
	assign lk.key_byte = r.key_byte;

	// all registers sit word aligned and back to back up to the mask register
	function automatic logic reg_hit(input logic [7:0] a);
		reg_hit = (a[1:0] == 2'h0) && (a <= `OFF_INT_MASK);
	endfunction

	function automatic logic is_data(input logic [7:0] a);
		is_data = (a >= `OFF_DATA_FIRST) && (a <= `OFF_DATA_LAST);
	endfunction

	// slot 0..7 = word0 low, word0 high, ... word3 high
	function automatic logic [2:0] data_slot(input logic [7:0] a);
		logic [7:0] d;
		d = a - `OFF_DATA_FIRST;
		data_slot = d[4:2];
	endfunction

	always_comb begin
		logic [7:0] wr;
		logic [2:0] op;
		logic [2:0] slot;
		logic [2:0] rslot;
		logic [7:0] rd;
		wr = r.w_byte;
		op = wr[6:4];
		slot = data_slot(r.aw_addr);
		rslot = data_slot(s_axi_araddr);
		rd = 8'h00;
		n = r;
		n.key_start = 1'b0;
		n.key_we = 1'b0;

		if (r.awready && s_axi_awvalid) begin
			n.aw_got = 1'b1;
			n.aw_addr = s_axi_awaddr;
		end
		if (r.wready && s_axi_wvalid) begin
			n.w_got = 1'b1;
			n.w_byte = s_axi_wdata[7:0];
			n.w_en = s_axi_wstrb[0];
		end
		if (r.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end

		// register write, one cycle after both address and data are held
		if (r.aw_got && r.w_got && !r.bvalid) begin
			n.aw_got = 1'b0;
			n.w_got = 1'b0;
			n.bvalid = 1'b1;
			n.bresp = reg_hit(r.aw_addr) ? `AXI_OKAY : `AXI_SLVERR;
			if (r.w_en && r.aw_addr == `OFF_CTRL) begin
				// a one here is ignored: only the key sequence unlocks
				if (!wr[`CTRL_UNLOCKED]) begin // R18
					n.unlocked = 1'b0; // R8
				end
				n.op_sel = op;
				n.arm = wr[`CTRL_ARM];
				n.rd_en = wr[`CTRL_RD_EN];
				if (wr[`CTRL_ARM] && op == `OP_UNLOCK) begin // R1
					n.key_start = 1'b1; // R2
				end
				// start bits only set from software; a zero written is ignored
				if (r.fl == flash_iap_pkg::FL_IDLE) begin
					if (wr[`CTRL_WSTART] && r.unlocked && wr[`CTRL_UNLOCKED]
						&& (op == `OP_WRITE || op == `OP_ERASE)) begin // R9
						n.wr_start = 1'b1;
						n.fl = flash_iap_pkg::FL_BUSY;
						n.flash_req = 1'b1;
						n.flash_wdata = r.data[0];
						if (op == `OP_ERASE) begin // R15
							n.flash_op = flash_iap_pkg::FOP_ERASE;
							n.flash_addr = {r.addr_hi, `BLOCK_BASE}; // R11 R12
						end else begin
							n.flash_op = flash_iap_pkg::FOP_WRITE;
							n.flash_addr = {r.addr_hi, r.addr_lo};
						end
					end else if (wr[`CTRL_RSTART] && wr[`CTRL_RD_EN] && op == `OP_READ) begin // R15
						n.rd_start = 1'b1;
						n.fl = flash_iap_pkg::FL_BUSY;
						n.flash_req = 1'b1;
						n.flash_op = flash_iap_pkg::FOP_READ;
						n.flash_addr = {r.addr_hi, r.addr_lo};
					end
				end
			end else if (r.w_en && r.aw_addr == `OFF_ADDR_LO) begin
				n.addr_lo = wr;
			end else if (r.w_en && r.aw_addr == `OFF_ADDR_HI) begin
				n.addr_hi = wr[3:0] & HI_MASK; // R12
			end else if (r.w_en && reg_hit(r.aw_addr) && is_data(r.aw_addr)) begin
				if (slot[0]) begin
					n.data[slot[2:1]][15:8] = wr; // R14
				end else begin
					n.data[slot[2:1]][7:0] = wr;
				end
				// key bytes go to the checker in the order they are written
				if (r.arm && slot >= `KEY_FIRST_SLOT) begin // R3
					n.key_we = 1'b1;
					n.key_idx = slot - `KEY_FIRST_SLOT;
					n.key_byte = wr;
				end
			end else if (r.w_en && r.aw_addr == `OFF_INT_STAT) begin
				n.int_stat = r.int_stat & ~wr[2:0];
			end else if (r.w_en && r.aw_addr == `OFF_INT_MASK) begin
				n.int_mask = wr[2:0];
			end
		end

		// hardware events come after the software write so a hardware set or clear beats the software one
		if (r.fl == flash_iap_pkg::FL_BUSY && flash_done) begin
			n.fl = flash_iap_pkg::FL_IDLE;
			n.flash_req = 1'b0;
			n.wr_start = 1'b0; // R16
			n.rd_start = 1'b0; // R17
			if (r.flash_op == flash_iap_pkg::FOP_READ) begin
				n.data[0] = flash_rdata; // R17
			end
			n.int_stat[`INT_DONE] = 1'b1;
		end
		// a new unlock request landing with a verdict is dropped with the arm bit; software re-arms
		if (lk.pass) begin
			n.unlocked = 1'b1; // R7
			n.arm = 1'b0; // R6
			n.key_start = 1'b0;
			n.int_stat[`INT_PASS] = 1'b1;
		end
		if (lk.fail) begin
			n.arm = 1'b0; // R5
			n.key_start = 1'b0;
			n.int_stat[`INT_FAIL] = 1'b1;
		end
		n.halt = n.wr_start | n.rd_start; // R13
		n.irq = |(n.int_stat & n.int_mask);

		// read channel
		if (r.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (r.arready && s_axi_arvalid) begin
			n.rvalid = 1'b1;
			n.rresp = reg_hit(s_axi_araddr) ? `AXI_OKAY : `AXI_SLVERR;
			if (s_axi_araddr == `OFF_CTRL) begin
				rd = {r.unlocked, r.op_sel, r.arm, r.wr_start, r.rd_en, r.rd_start};
			end else if (s_axi_araddr == `OFF_ADDR_LO) begin
				rd = r.addr_lo;
			end else if (s_axi_araddr == `OFF_ADDR_HI) begin
				rd = {4'h0, r.addr_hi};
			end else if (is_data(s_axi_araddr) && s_axi_araddr[1:0] == 2'h0) begin
				rd = rslot[0] ? r.data[rslot[2:1]][15:8] : r.data[rslot[2:1]][7:0];
			end else if (s_axi_araddr == `OFF_INT_STAT) begin
				rd = {5'h00, r.int_stat};
			end else if (s_axi_araddr == `OFF_INT_MASK) begin
				rd = {5'h00, r.int_mask};
			end
			n.rdata = {24'h000000, rd};
		end

		// one write and one read in flight at most
		n.awready = !n.aw_got && !n.bvalid;
		n.wready = !n.w_got && !n.bvalid;
		n.arready = !n.rvalid;
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			r <= '0;
		end else begin
			r <= n;
		end
	end

	assign s_axi_awready = r.awready;
	assign s_axi_wready = r.wready;
	assign s_axi_bresp = r.bresp;
	assign s_axi_bvalid = r.bvalid;
	assign s_axi_arready = r.arready;
	assign s_axi_rdata = r.rdata;
	assign s_axi_rresp = r.rresp;
	assign s_axi_rvalid = r.rvalid;
	assign flash_req = r.flash_req;
	assign flash_op = r.flash_op;
	assign flash_addr = r.flash_addr;
	assign flash_wdata = r.flash_wdata;
	assign cpu_halt = r.halt;
	assign irq = r.irq;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);

	sequence op_launch;
		$rose(r.flash_req);
	endsequence

	sequence op_finish;
		r.flash_req && flash_done;
	endsequence

	sequence read_finish;
		op_finish ##0 (r.flash_op == flash_iap_pkg::FOP_READ);
	endsequence

	sequence ctrl_exec;
		r.aw_got && r.w_got && !r.bvalid && r.w_en && r.aw_addr == `OFF_CTRL;
	endsequence

	unlock_start_a: assert property (r.key_start |-> (r.op_sel == `OP_UNLOCK && r.arm)) // R1
		else $error("unlock started without unlock code and arm");
	arm_same_write_a: assert property (r.key_start |=> u_key.r.st == flash_iap_pkg::CHK_RUN) // R2
		else $error("checker not running after unlock request");
	fail_clears_arm_a: assert property (lk.fail |=> !r.arm) // R5
		else $error("arm bit still set after failed unlock");
	pass_unlocks_a: assert property (lk.pass |=> (r.unlocked && !r.arm && r.int_stat[`INT_PASS])) // R6
		else $error("successful unlock not reported");
	flag_source_a: assert property ($rose(r.unlocked) |-> $past(lk.pass)) // R18
		else $error("unlocked flag set without key sequence");
	locked_launch_a: assert property ((op_launch ##0 (r.flash_op != flash_iap_pkg::FOP_READ))
		|-> $past(r.unlocked)) // R9
		else $error("array change launched while locked");
	erase_block_a: assert property ((r.flash_req && r.flash_op == flash_iap_pkg::FOP_ERASE)
		|-> (r.flash_addr[7:0] == `BLOCK_BASE && (r.flash_addr[11:8] & ~HI_MASK) == 4'h0)) // R12
		else $error("erase address not on a block boundary");
	halt_busy_a: assert property (r.flash_req |-> (r.halt && (r.wr_start || r.rd_start))) // R13
		else $error("cpu not halted during flash operation");
	done_release_a: assert property (op_finish |=> (!r.wr_start && !r.rd_start && !r.halt)) // R16
		else $error("start bits not cleared at completion");
	read_load_a: assert property (read_finish |=> r.data[0] == $past(flash_rdata)) // R17
		else $error("read word not loaded into data word 0");
	write_answer_a: assert property ((r.aw_got && r.w_got && !r.bvalid) |=> s_axi_bvalid)
		else $error("write response missing");
	irq_level_a: assert property ((r.int_stat & r.int_mask) != 3'h0 |-> ##[0:1] irq)
		else $error("interrupt not raised for unmasked status");
	lock_clear_a: assert property ((ctrl_exec ##0 (!r.w_byte[`CTRL_UNLOCKED] && !lk.pass)) |=> !r.unlocked) // R8
		else $error("unlocked flag survived a software clear");
	flag_one_a: assert property ((ctrl_exec ##0 (r.w_byte[`CTRL_UNLOCKED] && !r.unlocked && !lk.pass)) // R18
		|=> !r.unlocked)
		else $error("software write set the unlocked flag");
	halt_match_a: assert property (r.halt == (r.wr_start || r.rd_start)) // R13
		else $error("cpu halt differs from the start bits");
	key_gate_a: assert property (r.key_we |-> $past(r.arm)) // R3
		else $error("key byte passed on while not armed");
	addr_mask_a: assert property ((r.addr_hi & ~HI_MASK) == 4'h0) // R12
		else $error("address high holds bits beyond the variant");
	done_flag_a: assert property (op_finish |=> r.int_stat[`INT_DONE])
		else $error("completion not flagged");
	irq_quiet_a: assert property (((r.int_stat & r.int_mask) == 3'h0) |-> !irq)
		else $error("interrupt raised with nothing unmasked pending");
	read_answer_a: assert property ((s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read response missing");
	bvalid_hold_a: assert property ((s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
		else $error("write response dropped before acceptance");
	rvalid_hold_a: assert property ((s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
		else $error("read response changed before acceptance");
	req_hold_a: assert property ((r.flash_req && !flash_done) |=> (r.flash_req && $stable(r.flash_addr)
		&& $stable(r.flash_op)))
		else $error("flash request changed before completion");
endmodule // flash_iap_unlock_erase_ctrl

/* tb/flash_array_model.sv */
// behavioural program flash array answering the controller's erase, write and read requests
module flash_array_model #(
	parameter logic [15:0] ERASED_WORD = 16'h0000
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic slow,
	input wire logic flash_req,
	input wire flash_iap_pkg::flash_op_t flash_op,
	input wire logic [11:0] flash_addr,
	input wire logic [15:0] flash_wdata,
	output logic [15:0] flash_rdata,
	output logic flash_done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [15:0] mem [0:4095];
	logic busy;
	int wait_cnt;
	initial begin
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 16'(i);
		end
	end
	always @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			busy <= 1'b0;
			wait_cnt <= 0;
			flash_done <= 1'b0;
			flash_rdata <= 16'h0000;
		end else begin
			flash_done <= 1'b0;
			// no valid word outside a read answer, so the bus keeps toggling
			flash_rdata <= ~flash_rdata;
			if (flash_req && !busy) begin
				busy <= 1'b1;
				wait_cnt <= slow ? 20 : 1;
			end else if (busy && wait_cnt > 1) begin
				wait_cnt <= wait_cnt - 1;
			end else if (busy && wait_cnt == 1) begin
				wait_cnt <= 0;
				flash_done <= 1'b1;
				case (flash_op)
					flash_iap_pkg::FOP_ERASE: for (int i = 0; i < 256; i++) mem[{flash_addr[11:8], 8'(i)}] <= ERASED_WORD;
					flash_iap_pkg::FOP_WRITE: mem[flash_addr] <= flash_wdata;
					default: flash_rdata <= mem[flash_addr];
				endcase
			end else if (busy && !flash_req) begin
				busy <= 1'b0;
			end
		end
	end
endmodule // flash_array_model

/* tb/tb.sv */
// self-checking bench for the flash reprogramming controller
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SUB_HZ = 32000;
	localparam int TICKS = 300 * SUB_HZ / 1000000;
	localparam int SUB_CYC = 100000000 / SUB_HZ;
	typedef struct packed {logic [7:0] a; logic w; logic [7:0] d; logic [7:0] e; logic [1:0] r;} row_t;
	logic core_clk = 1'b0, rst_b = 1'b0, slow_sub_clock = 1'b0, slow = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, last_rdata;
	logic [3:0] s_axi_wstrb = 4'h1;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, last_bresp, last_rresp;
	logic flash_req, flash_done, cpu_halt, irq, req_q = 1'b0;
	flash_iap_pkg::flash_op_t flash_op;
	logic [11:0] flash_addr;
	logic [15:0] flash_wdata, flash_rdata;
	int mismatches = 0, samples_checked = 0, ops = 0, ops0;
	logic [7:0] key [6] = '{8'h00, 8'h04, 8'h0d, 8'h09, 8'hc3, 8'h40};
	row_t rows [10] = '{
		'{8'h00, 1'b0, 8'h00, 8'h00, 2'h0}, '{8'h28, 1'b0, 8'h00, 8'h00, 2'h0},
		'{8'h2c, 1'b0, 8'h00, 8'h00, 2'h0}, '{8'h28, 1'b1, 8'h5a, 8'h5a, 2'h0},
		'{8'h04, 1'b1, 8'ha5, 8'ha5, 2'h0}, '{8'h08, 1'b1, 8'hff, 8'h07, 2'h0},
		'{8'h00, 1'b1, 8'h80, 8'h00, 2'h0}, '{8'h34, 1'b1, 8'h11, 8'h00, 2'h2},
		'{8'h0d, 1'b1, 8'h77, 8'h00, 2'h2}, '{8'h0c, 1'b0, 8'h00, 8'h00, 2'h0}};
	flash_iap_unlock_erase_ctrl #(.ADDR_HI_W(3), .SUB_CLK_HZ(SUB_HZ)) u_flash_iap_unlock_erase_ctrl (.core_clk(core_clk),
		.rst_b(rst_b), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.slow_sub_clock(slow_sub_clock), .flash_req(flash_req), .flash_op(flash_op), .flash_addr(flash_addr),
		.flash_wdata(flash_wdata), .flash_rdata(flash_rdata), .flash_done(flash_done), .cpu_halt(cpu_halt), .irq(irq));
	flash_array_model u_flash_array_model (.core_clk(core_clk), .rst_b(rst_b), .slow(slow), .flash_req(flash_req),
		.flash_op(flash_op), .flash_addr(flash_addr), .flash_wdata(flash_wdata), .flash_rdata(flash_rdata),
		.flash_done(flash_done));
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	// the sub oscillator runs free and unrelated in phase to the core clock
	initial begin
		#3;
		forever #(SUB_CYC * 5) slow_sub_clock = ~slow_sub_clock;
	end
	always @(posedge core_clk) begin
		req_q <= flash_req;
		if (flash_req && !req_q) ops <= ops + 1;
	end
	task automatic finish_test;
		$display("mismatches %0d, samples_checked %0d", mismatches, samples_checked);
		if (mismatches == 0 && samples_checked > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task automatic note(input string m);
		mismatches++;
		$display("wrong value at %0t: %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) note($sformatf("got %h expected %h", got, exp));
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		int n;
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 200);
		last_bresp = s_axi_bresp;
		s_axi_bready <= 1'b0;
		if (n >= 200) note("write not answered");
		@(posedge core_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
		int n;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 200);
		last_rdata = s_axi_rdata;
		last_rresp = s_axi_rresp;
		s_axi_rready <= 1'b0;
		if (n >= 200) note("read not answered");
		@(posedge core_clk);
		chk(last_rdata & {24'h0, m}, {24'h0, e});
	endtask
	task automatic arm_key(input int nb, input int bad);
		wr(8'h00, 8'h68);
		for (int i = 0; i < nb; i++) begin
			wr(8'h14 + 8'(4 * i), (i == bad) ? key[i] ^ 8'h01 : key[i]);
		end
		repeat (4) @(posedge core_clk);
	endtask
	task automatic wait_idle;
		int n;
		n = 0;
		while (cpu_halt !== 1'b0 && n < 100) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 100) note("flash operation never ended");
	endtask
	initial begin
		repeat (80000) @(posedge core_clk);
		note("watchdog expired");
		finish_test();
	end
	initial begin
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		foreach (rows[i]) begin
			if (rows[i].w) begin
				wr(rows[i].a, rows[i].d);
				chk(32'(last_bresp), 32'(rows[i].r));
			end
			rd(rows[i].a, 8'hff, rows[i].e);
			chk(32'(last_rresp), 32'(rows[i].r));
		end
		// a write with the low lane disabled must leave the register alone
		s_axi_wstrb <= 4'h0;
		wr(8'h04, 8'hee);
		s_axi_wstrb <= 4'h1;
		rd(8'h04, 8'hff, 8'ha5);
		ops0 = ops;
		wr(8'h00, 8'h94);
		repeat (5) @(posedge core_clk);
		chk(ops, ops0);
		chk(32'(cpu_halt), 0);
		wr(8'h30, 8'h02);
		rd(8'h30, 8'hff, 8'h02);
		arm_key(4, 3);
		rd(8'h00, 8'h88, 8'h00);
		rd(8'h2c, 8'h02, 8'h02);
		chk(32'(irq), 1);
		wr(8'h2c, 8'h02);
		rd(8'h2c, 8'h02, 8'h00);
		chk(32'(irq), 0);
		arm_key(2, 7);
		repeat ((2 * TICKS - 3) * SUB_CYC / 2) @(posedge core_clk);
		rd(8'h00, 8'h08, 8'h08);
		repeat (2 * SUB_CYC) @(posedge core_clk);
		rd(8'h00, 8'h88, 8'h00);
		rd(8'h2c, 8'h02, 8'h02);
		wr(8'h2c, 8'h02);
		arm_key(6, 7);
		rd(8'h00, 8'h88, 8'h80);
		rd(8'h2c, 8'h01, 8'h01);
		chk(32'(irq), 0);
		wr(8'h2c, 8'h01);
		ops0 = ops;
		wr(8'h00, 8'ha4);
		repeat (5) @(posedge core_clk);
		chk(ops, ops0);
		wr(8'h08, 8'h05);
		wr(8'h04, 8'h37);
		slow <= 1'b1;
		wr(8'h00, 8'h94);
		chk(32'(cpu_halt), 1);
		chk(32'(flash_op), 32'(flash_iap_pkg::FOP_ERASE));
		chk(32'(flash_addr), 32'h500);
		wait_idle();
		rd(8'h00, 8'h04, 8'h00);
		chk(32'(u_flash_array_model.mem[12'h500]), 0);
		chk(32'(u_flash_array_model.mem[12'h5ff]), 0);
		chk(32'(u_flash_array_model.mem[12'h600]), 32'h600);
		chk(32'(u_flash_array_model.mem[12'h4ff]), 32'h4ff);
		wr(8'h0c, 8'h34);
		wr(8'h10, 8'h12);
		slow <= 1'b0;
		wr(8'h00, 8'h84);
		wait_idle();
		chk(32'(u_flash_array_model.mem[12'h537]), 32'h1234);
		rd(8'h2c, 8'h04, 8'h04);
		wr(8'h04, 8'h40);
		wr(8'h08, 8'h06);
		slow <= 1'b1;
		wr(8'h00, 8'hb3);
		chk(32'(cpu_halt), 1);
		chk(32'(flash_op), 32'(flash_iap_pkg::FOP_READ));
		wait_idle();
		rd(8'h00, 8'h01, 8'h00);
		rd(8'h0c, 8'hff, 8'h40);
		rd(8'h10, 8'hff, 8'h06);
		wr(8'h00, 8'h00);
		rd(8'h00, 8'h80, 8'h00);
		ops0 = ops;
		wr(8'h00, 8'h84);
		repeat (5) @(posedge core_clk);
		chk(ops, ops0);
		rst_b <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (2) @(posedge core_clk);
		rd(8'h28, 8'hff, 8'h00);
		rd(8'h00, 8'hff, 8'h00);
		finish_test();
	end
endmodule // tb
